// ### rtl/tpw_pkg.sv
package tpw_pkg;

	// ****************************************************************
	// Sizes and fixed codes
	// ****************************************************************
	localparam int          TPW_AXES        = 4;
	localparam int          TPW_INPUTS      = 80;
	localparam int          TPW_INPUT_FIRST = 1;
	localparam logic [7:0]  TPW_STOP_IN_POS = 8'h63;
	localparam logic [7:0]  TPW_STOP_RESET  = 8'h00;
	localparam logic [31:0] TPW_POS_RESET   = 32'h0000_0000;
	localparam logic [31:0] TPW_TIME_RESET  = 32'h0000_0000;

	// ****************************************************************
	// Time base
	// ****************************************************************
	localparam int TPW_CLK_PERIOD_NS = 100;
	localparam int TPW_MS_NS         = 1000000;
	localparam int TPW_CYC_PER_MS    = TPW_MS_NS / TPW_CLK_PERIOD_NS;

	// ****************************************************************
	// Instructions and states
	// ****************************************************************
	typedef enum logic [3:0] {
		op_wait_motion_done,
		op_wait_relative_distance,
		op_wait_repeat_distance,
		op_wait_absolute_position,
		op_wait_forward_crossing,
		op_wait_reverse_crossing,
		op_wait_in_position,
		op_wait_input_level,
		op_wait_slew_speed,
		op_wait_reference_time,
		op_wait_vector_distance,
		op_wait_delay_ms,
		op_relative_position_command
	} tpw_op_t;

	typedef enum logic {
		st_idle,
		st_wait
	} tpw_state_t;

endpackage : tpw_pkg

// ### rtl/tpw_sync.sv
`timescale 1ns/1ps
module tpw_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} tpw_sync_regs_t;

	tpw_sync_regs_t q;
	tpw_sync_regs_t d;

	always_comb begin
		d.meta = async_in;
		d.sync = q.meta;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.sync;

endmodule : tpw_sync

// ### rtl/tpw_wait_unit.sv
// Behaviour
// R1: Motion-done wait: listed axes, or all, complete.
// R2: Relative wait: commanded position reaches start+distance.
// R3: Repeat wait: distance from previous repeat/relative trip.
// R4: Absolute wait: named axis reaches absolute position.
// R5: Forward crossing wait; already passed releases immediately.
// R6: Reverse crossing wait; already passed releases immediately.
// R7: Crossing waits work on geared or auxiliary inputs.
// R8: In-position wait: profile done, encoder reached target.
// R9: Timeout releases, flags error, stop code 99.
// R10: Timeout redirects execution to the timeout handler.
// R11: Input wait: positive argument high, negative low.
// R12: Input wait accepts lines 1 to 80.
// R13: Slew wait: every named axis at slew speed.
// R14: Time wait zero sets reference; n waits.
// R15: Negative time wait advances reference to expiry.
// R16: Vector wait: path distance travelled reaches argument.
// R17: Vector distance measured from start or previous trip.
// R18: Delay wait stalls for given milliseconds.
// R19: Relative command while axis moving is rejected.
// R20: Position trips accurate within speed times sample.
// R21: Sequencer never advances while a wait pends.
// R22: Conditions evaluated every sample, release on first.
`timescale 1ns/1ps
module tpw_wait_unit
	import tpw_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = TPW_CYC_PER_MS
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Instruction from the sequencer
	input  wire logic             cmd_valid,
	output logic                  cmd_ready,
	input  wire tpw_op_t          cmd_op,
	input  wire logic [1:0]       cmd_axis,
	input  wire logic [4:0]       cmd_mask,
	input  wire logic             cmd_aux,
	input  wire logic [31:0]      cmd_arg,
	// Answers to the sequencer
	output logic                  stall,
	output logic                  wait_done,
	output logic                  cmd_reject,
	output logic                  pr_accept,
	output logic                  handler_jump,
	// Stop code and error report
	output logic                  mc_timeout_err,
	output logic                  stop_code_wr,
	output logic [1:0]            stop_code_axis,
	output logic [7:0]            stop_code,
	// Axis and profiler status
	input  wire logic             sample_tick,
	input  wire logic [3:0]       motion_done,
	input  wire logic             seq_done,
	input  wire logic [3:0]       axis_moving,
	input  wire logic [3:0]       at_slew,
	input  wire logic [3:0]       move_begin,
	input  wire logic             vec_begin,
	input  wire logic [3:0][31:0] cmd_pos,
	input  wire logic [3:0][31:0] enc_pos,
	input  wire logic [3:0][31:0] aux_pos,
	input  wire logic [31:0]      vec_dist,
	input  wire logic [3:0][15:0] in_position_timeout,
	// General inputs from pins
	input  wire logic [79:0]      in_lines
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		tpw_state_t       st;
		tpw_op_t          op;
		logic [1:0]       axis;
		logic [4:0]       mask;
		logic             aux;
		logic             up;
		logic [6:0]       iidx;
		logic [31:0]      target;
		logic [31:0]      wt_cnt;
		logic [15:0]      to_cnt;
		logic [15:0]      ms_div;
		logic [31:0]      now_ms;
		logic [31:0]      at_ref;
		logic [3:0][31:0] start_pos;
		logic [3:0][31:0] rep_ref;
		logic [31:0]      vec_ref;
		logic             done;
		logic             reject;
		logic             pr_ok;
		logic             terr;
		logic             jump;
		logic [7:0]       scode;
	} tpw_regs_t;

	tpw_regs_t   q;
	tpw_regs_t   d;
	logic [79:0] in_sync;
	logic        ms_tick;
	logic        hit;
	logic        tmo;
	logic [31:0] pos_q;
	logic [31:0] pos_c;
	logic [31:0] arg_abs;

	tpw_sync #(.W(TPW_INPUTS)) u_in_sync (
		.clk      (clk),
		.nrst     (nrst),
		.async_in (in_lines),
		.sync_out (in_sync)
	);

	function automatic logic crossed(input logic [31:0] pos,
		input logic [31:0] tgt, input logic up);
		if (up) begin
			crossed = $signed(pos) >= $signed(tgt);
		end else begin
			crossed = $signed(pos) <= $signed(tgt);
		end
	endfunction : crossed

	// ****************************************************************
	// Position source and trip condition
	// ****************************************************************
	always_comb begin
		// Auxiliary encoders and geared axes feed the crossing test.
		if (q.aux) begin
			pos_q = aux_pos[q.axis]; // see R7
		end else if (q.op == op_wait_in_position) begin
			pos_q = enc_pos[q.axis];
		end else begin
			pos_q = cmd_pos[q.axis];
		end
		if (cmd_aux) begin
			pos_c = aux_pos[cmd_axis]; // see R7
		end else begin
			pos_c = cmd_pos[cmd_axis];
		end
		arg_abs = cmd_arg[31] ? 32'(-cmd_arg) : cmd_arg;
		tmo = (in_position_timeout[q.axis] != 16'h0000) &&
			(q.to_cnt >= in_position_timeout[q.axis]);
		case (q.op)
			op_wait_motion_done: begin
				if (q.mask == 5'h00) begin
					hit = seq_done && (&motion_done); // see R1
				end else begin
					hit = &({seq_done, motion_done} | ~q.mask); // see R1
				end
			end
			op_wait_relative_distance, op_wait_repeat_distance,
			op_wait_absolute_position, op_wait_forward_crossing,
			op_wait_reverse_crossing: begin
				hit = crossed(pos_q, q.target, q.up); // see R2 R3 R4 R20
			end
			op_wait_in_position: begin
				hit = motion_done[q.axis] &&
					crossed(pos_q, q.target, q.up); // see R8
			end
			op_wait_input_level: begin
				hit = in_sync[q.iidx] == q.up; // see R11
			end
			op_wait_slew_speed: begin
				hit = &(at_slew | ~q.mask[3:0]); // see R13
			end
			op_wait_vector_distance: begin
				hit = $signed(vec_dist) >= $signed(q.target); // see R16
			end
			op_wait_reference_time: begin
				hit = $signed(q.now_ms - q.target) >= 0; // see R14 R15
			end
			op_wait_delay_ms: begin
				hit = q.wt_cnt == 32'h0000_0000; // see R18
			end
			default: begin
				hit = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.reject = 1'b0;
		d.pr_ok = 1'b0;
		d.terr = 1'b0;
		d.jump = 1'b0;
		ms_tick = q.ms_div == 16'(CYC_PER_MS - 1);
		d.ms_div = ms_tick ? 16'h0000 : q.ms_div + 16'h0001;
		if (ms_tick) begin
			d.now_ms = q.now_ms + 32'h0000_0001;
		end
		for (int i = 0; i < TPW_AXES; i++) begin
			if (move_begin[i]) begin
				d.start_pos[i] = cmd_pos[i];
				d.rep_ref[i] = cmd_pos[i];
			end
		end
		if (vec_begin) begin
			d.vec_ref = TPW_POS_RESET; // see R17
		end
		case (q.st)
			st_idle: begin
				if (cmd_valid) begin
					d.op = cmd_op;
					d.axis = cmd_axis;
					d.mask = cmd_mask;
					d.aux = cmd_aux;
					d.to_cnt = 16'h0000;
					d.target = cmd_arg;
					d.up = !cmd_arg[31];
					d.st = st_wait;
					case (cmd_op)
						op_relative_position_command: begin
							d.st = st_idle;
							if (axis_moving[cmd_axis]) begin
								d.reject = 1'b1; // see R19
							end else begin
								d.pr_ok = 1'b1;
							end
						end
						op_wait_relative_distance: begin
							d.target = d.start_pos[cmd_axis] + cmd_arg;
						end
						op_wait_repeat_distance: begin
							d.target = q.rep_ref[cmd_axis] + cmd_arg;
						end
						op_wait_absolute_position: begin
							d.up = $signed(cmd_arg) >= $signed(pos_c);
						end
						op_wait_in_position: begin
							d.up = $signed(cmd_arg) >=
								$signed(enc_pos[cmd_axis]);
						end
						op_wait_forward_crossing,
						op_wait_reverse_crossing: begin
							d.up = cmd_op == op_wait_forward_crossing;
							if (crossed(pos_c, cmd_arg, d.up)) begin
								d.st = st_idle; // see R5 R6
								d.done = 1'b1;
							end
						end
						op_wait_input_level: begin
							d.iidx = 7'(arg_abs - 32'(TPW_INPUT_FIRST));
							if (cmd_arg == 32'h0000_0000 ||
								arg_abs > 32'(TPW_INPUTS)) begin
								d.st = st_idle; // see R12
								d.reject = 1'b1;
							end
						end
						op_wait_reference_time: begin
							d.target = q.at_ref + arg_abs;
							if (cmd_arg == 32'h0000_0000) begin
								d.at_ref = q.now_ms; // see R14
								d.st = st_idle;
								d.done = 1'b1;
							end
						end
						op_wait_vector_distance: begin
							d.target = q.vec_ref + cmd_arg;
						end
						op_wait_delay_ms: begin
							d.wt_cnt = cmd_arg[31] ? 32'h0 : cmd_arg;
						end
						default: begin
						end
					endcase
				end
			end
			st_wait: begin
				if (ms_tick && q.wt_cnt != 32'h0000_0000) begin
					d.wt_cnt = q.wt_cnt - 32'h0000_0001;
				end
				if (ms_tick && q.op == op_wait_in_position &&
					q.to_cnt != 16'hffff) begin
					d.to_cnt = q.to_cnt + 16'h0001;
				end
				// Release only on a sample; stay stalled meanwhile.
				if (sample_tick && hit) begin // see R21 R22
					d.st = st_idle;
					d.done = 1'b1;
					case (q.op)
						op_wait_relative_distance,
						op_wait_repeat_distance: begin
							d.rep_ref[q.axis] = q.target; // see R3
						end
						op_wait_vector_distance: begin
							d.vec_ref = q.target; // see R17
						end
						op_wait_reference_time: begin
							if (!q.up) begin
								d.at_ref = q.target; // see R15
							end
						end
						default: begin
						end
					endcase
				end else if (sample_tick && tmo &&
					q.op == op_wait_in_position) begin
					d.st = st_idle; // see R9
					d.terr = 1'b1;
					d.scode = TPW_STOP_IN_POS;
					d.jump = 1'b1; // see R10
				end
			end
			default: begin
				d.st = st_idle;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
			q.st <= st_idle;
			q.now_ms <= TPW_TIME_RESET;
			q.at_ref <= TPW_TIME_RESET;
			q.scode <= TPW_STOP_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign cmd_ready      = q.st == st_idle;
	assign stall          = q.st == st_wait;
	assign wait_done      = q.done;
	assign cmd_reject     = q.reject;
	assign pr_accept      = q.pr_ok;
	assign handler_jump   = q.jump;
	assign mc_timeout_err = q.terr;
	assign stop_code_wr   = q.terr;
	assign stop_code_axis = q.axis;
	assign stop_code      = q.scode;

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_accept;
		cmd_valid && cmd_ready;
	endsequence

	sequence s_released;
		wait_done && !stall;
	endsequence

	property p_hold;
		@(posedge clk) disable iff (!nrst)
		stall && !sample_tick |=> stall;
	endproperty
	a_hold: assert property (p_hold) else $error("wait left early"); // see R21

	property p_timeout;
		@(posedge clk) disable iff (!nrst)
		mc_timeout_err |-> stop_code_wr && handler_jump && !stall &&
			stop_code == TPW_STOP_IN_POS;
	endproperty
	a_timeout: assert property (p_timeout) else $error("bad timeout"); // see R9

	property p_timeout_jump;
		@(posedge clk) disable iff (!nrst)
		handler_jump |-> $past(stall) && $past(q.op) == op_wait_in_position;
	endproperty
	a_timeout_jump: assert property (p_timeout_jump) else $error("bad jump"); // see R10

	property p_pr_reject;
		@(posedge clk) disable iff (!nrst)
		s_accept ##0 (cmd_op == op_relative_position_command &&
			axis_moving[cmd_axis]) |=> cmd_reject && !pr_accept && !stall;
	endproperty
	a_pr_reject: assert property (p_pr_reject) else $error("pr taken"); // see R19

	property p_input_range;
		@(posedge clk) disable iff (!nrst)
		s_accept ##0 (cmd_op == op_wait_input_level &&
			cmd_arg == 32'd81) |=> cmd_reject ##1 cmd_ready;
	endproperty
	a_input_range: assert property (p_input_range) else $error("range"); // see R12

	property p_ref_zero;
		@(posedge clk) disable iff (!nrst)
		s_accept ##0 (cmd_op == op_wait_reference_time &&
			cmd_arg == 32'd0) |=> s_released;
	endproperty
	a_ref_zero: assert property (p_ref_zero) else $error("at zero"); // see R14

	property p_fwd_past;
		@(posedge clk) disable iff (!nrst)
		s_accept ##0 (cmd_op == op_wait_forward_crossing &&
			$signed(cmd_aux ? aux_pos[cmd_axis] : cmd_pos[cmd_axis]) >=
			$signed(cmd_arg)) |=> s_released;
	endproperty
	a_fwd_past: assert property (p_fwd_past) else $error("fwd late"); // see R5

	property p_am_all;
		@(posedge clk) disable iff (!nrst)
		stall && q.op == op_wait_motion_done && q.mask == 5'h00 &&
			sample_tick && seq_done && motion_done == 4'hf |=> s_released;
	endproperty
	a_am_all: assert property (p_am_all) else $error("am stuck"); // see R1 R22

	property p_delay;
		@(posedge clk) disable iff (!nrst)
		stall && q.op == op_wait_delay_ms && q.wt_cnt > 32'd1 |=>
			stall [*2];
	endproperty
	a_delay: assert property (p_delay) else $error("delay short"); // see R18

	property p_input_hit;
		@(posedge clk) disable iff (!nrst)
		stall && q.op == op_wait_input_level && sample_tick &&
			in_sync[q.iidx] == q.up |=> s_released;
	endproperty
	a_input_hit: assert property (p_input_hit) else $error("ai stuck"); // see R11

endmodule : tpw_wait_unit

// ### sim/tpw_axis_model.sv
`timescale 1ns/1ps
module tpw_axis_model #(
	parameter int SMP = 5,
	parameter int STP = 10
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Motion request
	input  wire logic        ramp_en,
	// Status to the wait unit
	output logic             sample_tick,
	output logic [31:0]      pos
);
	int cnt;

	// ****************************************************************
	// Servo sample and commanded position
	// ****************************************************************
	// The position moves only on a sample, so a trip can come late by one
	// step of speed times sample period.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt         <= 0;
			sample_tick <= 1'b0;
			pos         <= 32'h0;
		end else begin
			sample_tick <= (cnt == SMP - 1);
			cnt         <= (cnt == SMP - 1) ? 0 : cnt + 1;
			if (sample_tick && ramp_en) begin
				pos <= pos + 32'(STP);
			end
		end
	end
endmodule : tpw_axis_model

// ### sim/test_trippoint_wait_unit.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("ERROR %s exp %0h got %0h", n, e, g); \
	end \
end

module test_trippoint_wait_unit import tpw_pkg::*;;
	localparam int CPM = 10;
	localparam int SMP = 5;
	localparam int STP = 10;
	logic clk, nrst, cmd_valid, cmd_aux, seq_done, vec_begin, ramp_en;
	logic cmd_ready, stall, wait_done, cmd_reject, pr_accept;
	logic handler_jump, mc_timeout_err, stop_code_wr, sample_tick;
	tpw_op_t          cmd_op;
	logic [1:0]       cmd_axis, stop_code_axis;
	logic [4:0]       cmd_mask, got;
	logic [31:0]      cmd_arg, ramp, vec_dist, tgt;
	logic [7:0]       stop_code;
	logic [3:0]       motion_done, axis_moving, at_slew, move_begin;
	logic [3:0][31:0] cmd_pos, enc_pos, aux_pos;
	logic [2:0][31:0] pos_hi;
	logic [3:0][15:0] in_position_timeout;
	logic [79:0]      in_lines;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	int st, cyc;

	assign cmd_pos = {pos_hi, ramp};
	initial clk = 1'b0;
	always #50 clk = ~clk;

	tpw_wait_unit #(.CYC_PER_MS(CPM)) u_dut (
		.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_axis(cmd_axis),
		.cmd_mask(cmd_mask), .cmd_aux(cmd_aux), .cmd_arg(cmd_arg),
		.stall(stall), .wait_done(wait_done), .cmd_reject(cmd_reject),
		.pr_accept(pr_accept), .handler_jump(handler_jump),
		.mc_timeout_err(mc_timeout_err), .stop_code_wr(stop_code_wr),
		.stop_code_axis(stop_code_axis), .stop_code(stop_code),
		.sample_tick(sample_tick), .motion_done(motion_done),
		.seq_done(seq_done), .axis_moving(axis_moving),
		.at_slew(at_slew), .move_begin(move_begin),
		.vec_begin(vec_begin), .cmd_pos(cmd_pos), .enc_pos(enc_pos),
		.aux_pos(aux_pos), .vec_dist(vec_dist),
		.in_position_timeout(in_position_timeout), .in_lines(in_lines));

	tpw_axis_model #(.SMP(SMP), .STP(STP)) u_axis (
		.clk(clk), .nrst(nrst), .ramp_en(ramp_en),
		.sample_tick(sample_tick), .pos(ramp));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	// Offers one instruction and records the first answer, which may be a
	// pulse in the very cycle after the instruction is taken.
	task automatic issue(input tpw_op_t op, input logic [1:0] ax,
		input logic [4:0] mk, input logic au, input logic [31:0] ag);
		st = 0;
		cyc = 0;
		@(negedge clk);
		cmd_op = op;
		cmd_axis = ax;
		cmd_mask = mk;
		cmd_aux = au;
		cmd_arg = ag;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		got = {wait_done, cmd_reject, pr_accept, mc_timeout_err,
			handler_jump};
		while (got == 5'h00 && cyc < 3000) begin
			if (stall === 1'b1 && cmd_ready === 1'b0) st++;
			@(negedge clk);
			cyc++;
			got = {wait_done, cmd_reject, pr_accept, mc_timeout_err,
				handler_jump};
		end
	endtask : issue

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			finish_test();
		end
	end

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_delay();
		issue(op_wait_delay_ms, 2'h0, 5'h00, 1'b0, 32'h2);
		`CHK("delay done", 1'b1, got[4])
		`CHK("delay held", 1'b1, st >= CPM)
		`CHK("delay bound", 1'b1, cyc <= 2 * CPM + SMP + 3)
	endtask : t_delay

	task automatic t_time();
		int t0;
		issue(op_wait_reference_time, 2'h0, 5'h00, 1'b0, 32'h0);
		`CHK("ref set", 1'b1, got[4] && st == 0)
		t0 = cycles;
		issue(op_wait_reference_time, 2'h0, 5'h00, 1'b0, 32'hffff_fffd);
		`CHK("neg time", 1'b1, got[4] && cycles - t0 > 2 * CPM)
		issue(op_wait_reference_time, 2'h0, 5'h00, 1'b0, 32'h2);
		`CHK("new ref", 1'b1, got[4] && st >= CPM)
	endtask : t_time

	task automatic t_rel();
		axis_moving = 4'h1;
		issue(op_relative_position_command, 2'h0, 5'h00, 1'b0, 32'h64);
		`CHK("move busy", 2'b10, got[3:2])
		axis_moving = 4'h0;
		issue(op_relative_position_command, 2'h0, 5'h00, 1'b0, 32'h64);
		`CHK("move free", 2'b01, got[3:2])
	endtask : t_rel

	task automatic t_input();
		in_lines[79] = 1'b1;
		in_lines[0] = 1'b1;
		repeat (3) @(negedge clk);
		issue(op_wait_input_level, 2'h0, 5'h00, 1'b0, 32'h50);
		`CHK("input 80", 2'b10, got[4:3])
		issue(op_wait_input_level, 2'h0, 5'h00, 1'b0, 32'h51);
		`CHK("input 81", 1'b1, got[3])
		issue(op_wait_input_level, 2'h0, 5'h00, 1'b0, 32'h0);
		`CHK("input 0", 1'b1, got[3])
		fork
			issue(op_wait_input_level, 2'h0, 5'h00, 1'b0, 32'hffff_ffff);
			begin
				repeat (30) @(negedge clk);
				in_lines[0] = 1'b0;
			end
		join
		`CHK("input low", 1'b1, got[4] && st >= 25)
	endtask : t_input

	task automatic t_cross();
		aux_pos[1] = 32'h1f4;
		issue(op_wait_forward_crossing, 2'h1, 5'h00, 1'b1, 32'h64);
		`CHK("fwd passed", 1'b1, got[4] && st == 0)
		issue(op_wait_reverse_crossing, 2'h1, 5'h00, 1'b1, 32'h3e8);
		`CHK("rev passed", 1'b1, got[4] && st == 0)
		fork
			issue(op_wait_reverse_crossing, 2'h1, 5'h00, 1'b1, 32'h64);
			begin
				repeat (20) @(negedge clk);
				aux_pos[1] = 32'h32;
			end
		join
		`CHK("rev reached", 1'b1, got[4] && st >= 15)
		ramp_en = 1'b1;
		tgt = ramp + 32'h64;
		issue(op_wait_forward_crossing, 2'h0, 5'h00, 1'b0, tgt);
		`CHK("fwd reached", 1'b1, got[4] && st > 0 && ramp >= tgt)
		tgt = ramp + 32'hc8;
		issue(op_wait_absolute_position, 2'h0, 5'h00, 1'b0, tgt);
		`CHK("abs reached", 1'b1, got[4] && ramp >= tgt)
		`CHK("abs error", 1'b1, ramp - tgt <= STP)
		ramp_en = 1'b0;
	endtask : t_cross

	task automatic t_dist();
		move_begin = 4'h1;
		tgt = ramp;
		@(negedge clk);
		move_begin = 4'h0;
		ramp_en = 1'b1;
		issue(op_wait_relative_distance, 2'h0, 5'h00, 1'b0, 32'h64);
		`CHK("rel reached", 1'b1, got[4] && ramp - tgt - 32'h64 <= STP)
		issue(op_wait_repeat_distance, 2'h0, 5'h00, 1'b0, 32'h64);
		`CHK("rep reached", 1'b1, got[4] && st > 0)
		`CHK("rep error", 1'b1, ramp - tgt - 32'hc8 <= STP)
		ramp_en = 1'b0;
	endtask : t_dist

	task automatic t_status();
		motion_done = 4'h1;
		fork
			issue(op_wait_motion_done, 2'h0, 5'h00, 1'b0, 32'h0);
			begin
				repeat (20) @(negedge clk);
				motion_done = 4'hf;
				repeat (20) @(negedge clk);
				seq_done = 1'b1;
			end
		join
		`CHK("all done", 1'b1, got[4] && st >= 35)
		{motion_done, seq_done} = 5'h04;
		issue(op_wait_motion_done, 2'h0, 5'h02, 1'b0, 32'h0);
		`CHK("axis done", 1'b1, got[4] && cyc <= SMP + 3)
		at_slew = 4'h1;
		fork
			issue(op_wait_slew_speed, 2'h0, 5'h03, 1'b0, 32'h0);
			begin
				repeat (20) @(negedge clk);
				at_slew = 4'h3;
			end
		join
		`CHK("slew", 1'b1, got[4] && st >= 15)
	endtask : t_status

	task automatic t_vector();
		vec_begin = 1'b1;
		@(negedge clk);
		vec_begin = 1'b0;
		fork
			issue(op_wait_vector_distance, 2'h0, 5'h00, 1'b0, 32'h64);
			begin
				repeat (20) @(negedge clk);
				vec_dist = 32'h64;
			end
		join
		`CHK("vec first", 1'b1, got[4] && st >= 15)
		vec_dist = 32'h96;
		fork
			issue(op_wait_vector_distance, 2'h0, 5'h00, 1'b0, 32'h64);
			begin
				repeat (20) @(negedge clk);
				vec_dist = 32'hc8;
			end
		join
		`CHK("vec next", 1'b1, got[4] && st >= 15)
	endtask : t_vector

	task automatic t_inpos();
		motion_done = 4'hf;
		in_position_timeout[2] = 16'h1;
		issue(op_wait_in_position, 2'h2, 5'h00, 1'b0, 32'h1000);
		`CHK("timeout", 5'h03, got)
		`CHK("stop write", 1'b1, stop_code_wr)
		`CHK("stop code", 8'h63, stop_code)
		`CHK("stop axis", 2'h2, stop_code_axis)
		enc_pos[1] = 32'h64;
		issue(op_wait_in_position, 2'h1, 5'h00, 1'b0, 32'h64);
		`CHK("in position", 5'h10, got)
	endtask : t_inpos

	initial begin
		{cmd_valid, cmd_aux, seq_done, vec_begin, ramp_en} = 5'h00;
		cmd_op = op_wait_motion_done;
		{cmd_axis, cmd_mask, cmd_arg} = '0;
		{motion_done, axis_moving, at_slew, move_begin} = 16'h0;
		{pos_hi, enc_pos, aux_pos, vec_dist} = '0;
		in_position_timeout = '0;
		in_lines = '0;
		nrst = 1'b0;
		repeat (5) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		`CHK("reset stop code", 8'h00, stop_code)
		`CHK("reset ready", 2'b10, {cmd_ready, stall})
		t_delay();
		t_time();
		t_rel();
		t_input();
		t_cross();
		t_dist();
		t_status();
		t_vector();
		t_inpos();
		finish_test();
	end
endmodule : test_trippoint_wait_unit
